// [design/rtcvac_pkg.sv]
// constants and helpers for the calendar clock value, alarm window and trim
// assumes an apb master and a synchronous 32.768 khz timebase tick input
// Function
// - time window pointer 00 min/sec, 01 weekday/hours, 10 month/day, 11 year
// - alarm pointer lives in alarm config bits 1:0 and picks the pair
// - every access to alarm window high byte steps the pointer down by one
// - pointer sticks at zero, showing alarm minutes/seconds until rewritten
// - alarm codes 00 min/sec, 01 weekday/hours, 10 month/day, 11 nothing
// - drift trim holds an 8-bit two's-complement value in its low byte
// - once per minute the trim times four is applied as timebase pulses
// - negative trim removes pulses, positive trim adds pulses
// - counting runs from the 32.768 khz timebase; trim counts those cycles
package rtcvac_pkg;
  // register byte addresses
  localparam logic [7:0] TIME_PTR_ADDR = 8'h00;
  localparam logic [7:0] TIME_HIGH_ADDR = 8'h04;
  localparam logic [7:0] TIME_LOW_ADDR = 8'h08;
  localparam logic [7:0] ALARM_CFG_ADDR = 8'h0C;
  localparam logic [7:0] ALARM_HIGH_ADDR = 8'h10;
  localparam logic [7:0] ALARM_LOW_ADDR = 8'h14;
  localparam logic [7:0] TRIM_ADDR = 8'h18;
  localparam logic [7:0] CLOCK_CFG_ADDR = 8'h1C;
  // field positions
  localparam int ENABLE_BIT = 0;
  // window pointer codes
  localparam logic [1:0] PTR_MIN_SEC = 2'h0;
  localparam logic [1:0] PTR_WD_HR = 2'h1;
  localparam logic [1:0] PTR_MON_DAY = 2'h2;
  localparam logic [1:0] PTR_YEAR = 2'h3;
  // timebase and calendar counts
  localparam logic [14:0] TICKS_PER_SEC_M1 = 15'h7FFF;
  localparam logic [7:0] LAST_SECOND = 8'h3B;
  localparam logic [7:0] LAST_MINUTE = 8'h3B;
  localparam logic [7:0] LAST_HOUR = 8'h17;
  localparam logic [7:0] LAST_WEEKDAY = 8'h06;
  localparam logic [7:0] LAST_MONTH = 8'h0C;
  localparam logic [7:0] LAST_YEAR = 8'h63;
  localparam logic [7:0] TRIM_SCALE_SHIFT = 8'h02;
  // reset values
  localparam logic [7:0] FIRST_DAY = 8'h01;
  localparam logic [7:0] FIRST_MONTH = 8'h01;
  localparam logic [1:0] PTR_RESET = 2'h0;
  localparam logic [7:0] TRIM_RESET = 8'h00;

  function automatic logic [7:0] days_in_month(input logic [7:0] mon,
                                              input logic [7:0] yr);
    logic [7:0] d;
    d = 8'h1F;
    if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h0B) begin
      d = 8'h1E;
    end else if (mon == 8'h02) begin
      d = (yr[1:0] == 2'h0) ? 8'h1D : 8'h1C;
    end
    return d;
  endfunction

  // trim magnitude times four, in timebase pulses
  function automatic logic [9:0] trim_pulses(input logic [7:0] trim);
    logic [7:0] mag;
    mag = trim[7] ? 8'((~trim) + 8'h01) : trim;
    return {mag, 2'h0};
  endfunction
endpackage

// [design/rtcvac_calendar.sv]
// calendar counters from seconds up to year, binary coded
// assumes sec_tick is a one-cycle pulse; a write in the same cycle wins
`timescale 1ns/1ps
module rtcvac_calendar (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // advance
  input wire logic sec_tick,
  // software write through the time window
  input wire logic wr_hi,
  input wire logic wr_lo,
  input wire logic [1:0] wr_sel,
  input wire logic [7:0] wr_data,
  // current fields
  output logic [7:0] seconds,
  output logic [7:0] minutes,
  output logic [7:0] hours,
  output logic [7:0] weekday,
  output logic [7:0] day,
  output logic [7:0] month,
  output logic [7:0] year
);
  logic end_day;

  assign end_day = seconds == rtcvac_pkg::LAST_SECOND &&
                   minutes == rtcvac_pkg::LAST_MINUTE &&
                   hours == rtcvac_pkg::LAST_HOUR;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seconds <= 8'h00;
      minutes <= 8'h00;
      hours <= 8'h00;
      weekday <= 8'h00;
      day <= rtcvac_pkg::FIRST_DAY;
      month <= rtcvac_pkg::FIRST_MONTH;
      year <= 8'h00;
    end else if (wr_hi || wr_lo) begin
      // direct field access, no other effect
      case (wr_sel)
        rtcvac_pkg::PTR_MIN_SEC: begin
          if (wr_hi) minutes <= wr_data;
          if (wr_lo) seconds <= wr_data;
        end
        rtcvac_pkg::PTR_WD_HR: begin
          if (wr_hi) weekday <= wr_data;
          if (wr_lo) hours <= wr_data;
        end
        rtcvac_pkg::PTR_MON_DAY: begin
          if (wr_hi) month <= wr_data;
          if (wr_lo) day <= wr_data;
        end
        default: begin
          if (wr_lo) year <= wr_data;
        end
      endcase
    end else if (sec_tick) begin
      seconds <= (seconds == rtcvac_pkg::LAST_SECOND) ? 8'h00
                 : 8'(seconds + 8'h01);
      if (seconds == rtcvac_pkg::LAST_SECOND) begin
        minutes <= (minutes == rtcvac_pkg::LAST_MINUTE) ? 8'h00
                   : 8'(minutes + 8'h01);
        if (minutes == rtcvac_pkg::LAST_MINUTE) begin
          hours <= (hours == rtcvac_pkg::LAST_HOUR) ? 8'h00
                   : 8'(hours + 8'h01);
        end
      end
      if (end_day) begin
        weekday <= (weekday == rtcvac_pkg::LAST_WEEKDAY) ? 8'h00
                   : 8'(weekday + 8'h01);
        if (day >= rtcvac_pkg::days_in_month(month, year)) begin
          day <= rtcvac_pkg::FIRST_DAY;
          if (month >= rtcvac_pkg::LAST_MONTH) begin
            month <= rtcvac_pkg::FIRST_MONTH;
            year <= (year == rtcvac_pkg::LAST_YEAR) ? 8'h00
                    : 8'(year + 8'h01);
          end else begin
            month <= 8'(month + 8'h01);
          end
        end else begin
          day <= 8'(day + 8'h01);
        end
      end
    end
  end
endmodule // rtcvac_calendar

// [design/rtcvac_top.sv]
// calendar clock: apb register windows, alarm pointer, per-minute drift trim
// assumes apb signals and tick_32k are synchronous to clock
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
module rtcvac_top (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // timebase and status
  input wire logic tick_32k,
  output logic sec_pulse,
  output logic timer_enable
);
  logic setup, access, mapped, wr, rd_alarm_hi;
  logic [1:0] time_ptr_q, alarm_ptr_q;
  logic [7:0] trim_q;
  logic [7:0] al_min_q, al_sec_q, al_wd_q, al_hr_q, al_mon_q, al_day_q;
  logic [14:0] presc_q;
  logic [9:0] swallow_q;
  logic [31:0] prdata_q, rd_mux;
  logic err_q, sec_tick, minute_wrap, t_wr_hi, t_wr_lo;
  logic [7:0] sec, min, hr, wd, dy, mon, yr, t_hi, t_lo, a_hi, a_lo;

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr = access && pwrite && pstrb[0];
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = access && err_q;
  assign mapped = paddr inside {rtcvac_pkg::TIME_PTR_ADDR,
    rtcvac_pkg::TIME_HIGH_ADDR, rtcvac_pkg::TIME_LOW_ADDR,
    rtcvac_pkg::ALARM_CFG_ADDR, rtcvac_pkg::ALARM_HIGH_ADDR,
    rtcvac_pkg::ALARM_LOW_ADDR, rtcvac_pkg::TRIM_ADDR,
    rtcvac_pkg::CLOCK_CFG_ADDR};
  assign rd_alarm_hi = access && paddr == rtcvac_pkg::ALARM_HIGH_ADDR;
  assign t_wr_hi = wr && paddr == rtcvac_pkg::TIME_HIGH_ADDR;
  assign t_wr_lo = wr && paddr == rtcvac_pkg::TIME_LOW_ADDR;

  rtcvac_calendar u_cal (
    .clock(clock),
    .rst_n(rst_n),
    .sec_tick(sec_tick),
    .wr_hi(t_wr_hi),
    .wr_lo(t_wr_lo),
    .wr_sel(time_ptr_q),
    .wr_data(pwdata[7:0]),
    .seconds(sec),
    .minutes(min),
    .hours(hr),
    .weekday(wd),
    .day(dy),
    .month(mon),
    .year(yr)
  );

  // time window mux; year code leaves the high byte empty
  always_comb begin
    case (time_ptr_q)
      rtcvac_pkg::PTR_MIN_SEC: begin t_hi = min; t_lo = sec; end
      rtcvac_pkg::PTR_WD_HR: begin t_hi = wd; t_lo = hr; end
      rtcvac_pkg::PTR_MON_DAY: begin t_hi = mon; t_lo = dy; end
      default: begin t_hi = 8'h00; t_lo = yr; end
    endcase
  end

  always_comb begin
    case (alarm_ptr_q)
      rtcvac_pkg::PTR_MIN_SEC: begin a_hi = al_min_q; a_lo = al_sec_q; end
      rtcvac_pkg::PTR_WD_HR: begin a_hi = al_wd_q; a_lo = al_hr_q; end
      rtcvac_pkg::PTR_MON_DAY: begin a_hi = al_mon_q; a_lo = al_day_q; end
      default: begin a_hi = 8'h00; a_lo = 8'h00; end
    endcase
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (paddr == rtcvac_pkg::TIME_PTR_ADDR) begin
      rd_mux[1:0] = time_ptr_q;
    end else if (paddr == rtcvac_pkg::TIME_HIGH_ADDR) begin
      rd_mux[7:0] = t_hi;
    end else if (paddr == rtcvac_pkg::TIME_LOW_ADDR) begin
      rd_mux[7:0] = t_lo;
    end else if (paddr == rtcvac_pkg::ALARM_CFG_ADDR) begin
      rd_mux[1:0] = alarm_ptr_q;
    end else if (paddr == rtcvac_pkg::ALARM_HIGH_ADDR) begin
      rd_mux[7:0] = a_hi;
    end else if (paddr == rtcvac_pkg::ALARM_LOW_ADDR) begin
      rd_mux[7:0] = a_lo;
    end else if (paddr == rtcvac_pkg::TRIM_ADDR) begin
      rd_mux[7:0] = trim_q;
    end else if (paddr == rtcvac_pkg::CLOCK_CFG_ADDR) begin
      rd_mux[rtcvac_pkg::ENABLE_BIT] = timer_enable;
    end
  end

  // read data captured in the setup cycle, so it is a flop in access
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
      err_q <= !mapped;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      time_ptr_q <= rtcvac_pkg::PTR_RESET;
    end else if (wr && paddr == rtcvac_pkg::TIME_PTR_ADDR) begin
      time_ptr_q <= pwdata[1:0];
    end
  end

  // alarm pointer: software write, else step down on high byte access
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      alarm_ptr_q <= rtcvac_pkg::PTR_RESET;
    end else if (wr && paddr == rtcvac_pkg::ALARM_CFG_ADDR) begin
      alarm_ptr_q <= pwdata[1:0];
    end else if (rd_alarm_hi && alarm_ptr_q != 2'h0) begin
      alarm_ptr_q <= 2'(alarm_ptr_q - 2'h1);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      al_min_q <= 8'h00;
      al_sec_q <= 8'h00;
      al_wd_q <= 8'h00;
      al_hr_q <= 8'h00;
      al_mon_q <= 8'h00;
      al_day_q <= 8'h00;
    end else if (wr && paddr == rtcvac_pkg::ALARM_HIGH_ADDR) begin
      case (alarm_ptr_q)
        rtcvac_pkg::PTR_MIN_SEC: al_min_q <= pwdata[7:0];
        rtcvac_pkg::PTR_WD_HR: al_wd_q <= pwdata[7:0];
        rtcvac_pkg::PTR_MON_DAY: al_mon_q <= pwdata[7:0];
        default: ;
      endcase
    end else if (wr && paddr == rtcvac_pkg::ALARM_LOW_ADDR) begin
      case (alarm_ptr_q)
        rtcvac_pkg::PTR_MIN_SEC: al_sec_q <= pwdata[7:0];
        rtcvac_pkg::PTR_WD_HR: al_hr_q <= pwdata[7:0];
        rtcvac_pkg::PTR_MON_DAY: al_day_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // trim is taken at any time; writing mid-minute is software's hazard
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      trim_q <= rtcvac_pkg::TRIM_RESET;
      timer_enable <= 1'b0;
    end else if (wr && paddr == rtcvac_pkg::TRIM_ADDR) begin
      trim_q <= pwdata[7:0];
    end else if (wr && paddr == rtcvac_pkg::CLOCK_CFG_ADDR) begin
      timer_enable <= pwdata[rtcvac_pkg::ENABLE_BIT];
    end
  end

  assign sec_tick = timer_enable && tick_32k && swallow_q == 10'h000 &&
                    presc_q == rtcvac_pkg::TICKS_PER_SEC_M1;
  assign minute_wrap = sec_tick && sec == rtcvac_pkg::LAST_SECOND;

  // positive trim starts the next second ahead, negative swallows ticks
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      presc_q <= 15'h0000;
      swallow_q <= 10'h000;
    end else if (minute_wrap) begin
      presc_q <= trim_q[7] ? 15'h0000
                 : {5'h00, rtcvac_pkg::trim_pulses(trim_q)};
      swallow_q <= trim_q[7] ? rtcvac_pkg::trim_pulses(trim_q)
                   : 10'h000;
    end else if (timer_enable && tick_32k) begin
      if (swallow_q != 10'h000) begin
        swallow_q <= 10'(swallow_q - 10'h001);
      end else begin
        presc_q <= 15'(presc_q + 15'h0001);
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sec_pulse <= 1'b0;
    end else begin
      sec_pulse <= sec_tick;
    end
  end

  time_sel_a: assert property (@(posedge clock) disable iff (!rst_n)
    setup && !pwrite && paddr == rtcvac_pkg::TIME_HIGH_ADDR &&
    time_ptr_q == 2'h3 |=> prdata == 32'h0000_0000)
    else $error("year code high byte not empty");
  alarm_sel_a: assert property (@(posedge clock) disable iff (!rst_n)
    setup && !pwrite && paddr == rtcvac_pkg::ALARM_LOW_ADDR &&
    alarm_ptr_q == 2'h1 |=> prdata[7:0] == $past(al_hr_q))
    else $error("alarm code 01 low byte not hours");
  ptr_step_a: assert property (@(posedge clock) disable iff (!rst_n)
    rd_alarm_hi && alarm_ptr_q != 2'h0 |=>
    alarm_ptr_q == 2'($past(alarm_ptr_q) - 2'h1))
    else $error("alarm pointer did not step down");
  ptr_floor_a: assert property (@(posedge clock) disable iff (!rst_n)
    rd_alarm_hi && alarm_ptr_q == 2'h0 |=> alarm_ptr_q == 2'h0 [*2])
    else $error("alarm pointer left zero");
  alarm_none_a: assert property (@(posedge clock) disable iff (!rst_n)
    setup && !pwrite && paddr == rtcvac_pkg::ALARM_HIGH_ADDR &&
    alarm_ptr_q == 2'h3 |=> prdata == 32'h0000_0000)
    else $error("alarm code 11 returned data");
  trim_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
    wr && paddr == rtcvac_pkg::TRIM_ADDR |=> trim_q == $past(pwdata[7:0]))
    else $error("trim value not stored");
  trim_add_a: assert property (@(posedge clock) disable iff (!rst_n)
    minute_wrap && !trim_q[7] |=>
    presc_q == {5'h00, $past(trim_q), 2'h0})
    else $error("positive trim not added");
  trim_sub_a: assert property (@(posedge clock) disable iff (!rst_n)
    minute_wrap && trim_q[7] |=> swallow_q == 10'(-{{2{$past(trim_q[7])}},
    $past(trim_q), 2'h0}) && presc_q == 15'h0000)
    else $error("negative trim not removed");
  stop_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    !timer_enable |=> $stable(presc_q) && !sec_pulse)
    else $error("counter ran while disabled");
  step_cover_c: cover property (@(posedge clock) disable iff (!rst_n)
    rd_alarm_hi && alarm_ptr_q == 2'h2);
  minute_cover_c: cover property (@(posedge clock) disable iff (!rst_n)
    minute_wrap && trim_q[7]);
  err_cover_c: cover property (@(posedge clock) disable iff (!rst_n)
    pslverr);
endmodule // rtcvac_top

// [verification/rtcvac_top_test.sv]
// self-checking bench for the calendar clock register windows and trim
// assumes rtcvac_top and rtcvac_pkg are compiled first; apb master inside
`timescale 1ns/1ps
module rtcvac_top_test;
  localparam logic [7:0] A_TP = rtcvac_pkg::TIME_PTR_ADDR;
  localparam logic [7:0] A_TH = rtcvac_pkg::TIME_HIGH_ADDR;
  localparam logic [7:0] A_TL = rtcvac_pkg::TIME_LOW_ADDR;
  localparam logic [7:0] A_AC = rtcvac_pkg::ALARM_CFG_ADDR;
  localparam logic [7:0] A_AH = rtcvac_pkg::ALARM_HIGH_ADDR;
  localparam logic [7:0] A_AL = rtcvac_pkg::ALARM_LOW_ADDR;
  localparam logic [7:0] A_TR = rtcvac_pkg::TRIM_ADDR;
  localparam logic [7:0] A_CC = rtcvac_pkg::CLOCK_CFG_ADDR;
  logic clock, rst_n, psel, penable, pwrite, tick_32k, tick_on;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic pready, pslverr, sec_pulse, timer_enable, er;
  int err_total, tests_run, cyc, gap;

  rtcvac_top uut (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tick_32k(tick_32k), .sec_pulse(sec_pulse),
    .timer_enable(timer_enable));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // one timebase tick per clock while enabled, the fastest legal rate
  always @(posedge clock) begin
    tick_32k <= tick_on;
  end

  // clocks since the last seconds pulse, so register traffic between
  // pulses does not disturb the measured length of a second
  always @(posedge clock) begin
    if (sec_pulse === 1'b1) begin
      gap <= 1;
    end else begin
      gap <= gap + 1;
    end
  end

  task end_of_test;
    $display("compares %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task done(input string name);
    $display("test %s finished, mismatches so far %0d", name, err_total);
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic [3:0] s);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clock);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      err_total++;
      end_of_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask

  task rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'hF);
    check(rd, exp);
  endtask

  // waits for the next seconds pulse, bounded; cyc is pulse to pulse
  task wait_pulse;
    int n;
    for (n = 0; n < 40000; n++) begin
      @(posedge clock);
      if (sec_pulse === 1'b1) break;
    end
    cyc = gap;
    if (n == 40000) begin
      err_total++;
      end_of_test();
    end
  endtask

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    tick_on = 1'b0;
    tick_32k = 1'b0;
    err_total = 0;
    tests_run = 0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    rchk(A_TH, 32'h0);
    check(er, 1'b0);
    rchk(A_TL, 32'h0);
    wr(A_TP, 32'h2);
    rchk(A_TP, 32'h2);
    rchk(A_TH, 32'h1);
    rchk(A_TL, 32'h1);
    rchk(A_TR, 32'h0);
    done("reset");
    wr(A_TP, 32'h1);
    wr(A_TH, 32'h3);
    wr(A_TL, 32'h5);
    rchk(A_TH, 32'h3);
    rchk(A_TL, 32'h5);
    rchk(A_TP, 32'h1);
    wr(A_TP, 32'h3);
    wr(A_TL, 32'h12);
    apb(1'b1, A_TL, 32'h34, 4'h0);
    rchk(A_TL, 32'h12);
    rchk(A_TH, 32'h0);
    rchk(A_TP, 32'h3);
    done("time_window");
    wr(A_AC, 32'h2);
    wr(A_AL, 32'h9);
    rchk(A_AC, 32'h2);
    wr(A_AH, 32'h7);
    rchk(A_AC, 32'h1);
    wr(A_AL, 32'h0A);
    wr(A_AH, 32'h4);
    rchk(A_AC, 32'h0);
    wr(A_AH, 32'h22);
    rchk(A_AC, 32'h0);
    wr(A_AL, 32'h33);
    wr(A_AC, 32'h2);
    rchk(A_AL, 32'h9);
    rchk(A_AH, 32'h7);
    rchk(A_AL, 32'h0A);
    rchk(A_AH, 32'h4);
    rchk(A_AL, 32'h33);
    rchk(A_AH, 32'h22);
    rchk(A_AC, 32'h0);
    wr(A_AC, 32'h3);
    rchk(A_AL, 32'h0);
    wr(A_AH, 32'h55);
    rchk(A_AC, 32'h2);
    rchk(A_AH, 32'h7);
    done("alarm_window");
    apb(1'b0, 8'h20, 32'h0, 4'hF);
    check(rd, 32'h0);
    check(er, 1'b1);
    wr(A_TR, 32'hFE);
    rchk(A_TR, 32'hFE);
    wr(A_TR, 32'h1FF);
    rchk(A_TR, 32'hFF);
    done("trim_and_map");
    // trim written with the timer still off
    wr(A_TR, 32'h2);
    wr(A_TP, 32'h0);
    wr(A_TH, 32'h5);
    wr(A_TL, 32'h3B);
    wr(A_CC, 32'h1);
    // enable flop settles after the access edge
    @(negedge clock);
    check(timer_enable, 1'b1);
    tick_on <= 1'b1;
    wait_pulse();
    // just after the pulse: arm -2 for the next rollover, back to second 59
    wr(A_TR, 32'hFE);
    wr(A_TL, 32'h3B);
    // after the minute rollover, +2 shortens the next second by 8 ticks
    wait_pulse();
    check(cyc, 32'd32760);
    check(cyc, 32'd32768 - 32'd8);
    // -2 swallows 8 ticks, so the following second is 8 ticks longer
    wait_pulse();
    check(cyc, 32'd32768 + 32'd8);
    tick_on <= 1'b0;
    wr(A_CC, 32'h0);
    @(negedge clock);
    check(timer_enable, 1'b0);
    rchk(A_TL, 32'h1);
    rchk(A_TH, 32'h7);
    done("counting");
    end_of_test();
  end
endmodule // rtcvac_top_test
